// *** rtl/fph_device.sv ***
// Purpose: protection, power mode and hold logic of the serial flash end
// Assumes: all link pins are asynchronous and pass two flip-flops
// Notes: protect bits are held in flops; they return to zero on nrst
//
// Chosen here: the edge detectors on clock and select, and the power mode rule.
module fph_device
	import fph_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Link
	fph_link_if.dev lnk,
	// Observed state
	output fph_power_type power_mode,
	output logic [7:0] status,
	output logic otp_mode,
	output logic op_accept,
	output logic op_reject
);

	fph_dev_type q;
	fph_dev_type d;

	always_comb begin
		logic sel;
		logic sclk_low;
		logic rise;
		logic fall;
		logic cs_rise;
		logic whole;
		logic modifying;
		logic start;
		logic [7:0] byte_in;
		sel = 1'b0;
		sclk_low = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		cs_rise = 1'b0;
		whole = 1'b0;
		modifying = 1'b0;
		start = 1'b0;
		byte_in = 8'h00;
		d = q;
		d.op_accept = 1'b0;
		d.op_reject = 1'b0;

		// Synchronisers; stage 0 feeds only stage 1
		d.sclk_sy = {q.sclk_sy[1:0], lnk.sclk};
		d.cs_sy = {q.cs_sy[1:0], lnk.select_n};
		d.si_sy = {q.si_sy[0], lnk.serial_in};
		d.hold_sy = {q.hold_sy[0], lnk.hold_n};
		d.wp_sy = {q.wp_sy[0], lnk.write_protect_n};

		sel = ~q.cs_sy[1];
		sclk_low = ~q.sclk_sy[1];
		rise = q.sclk_sy[1] & ~q.sclk_sy[2];
		fall = ~q.sclk_sy[1] & q.sclk_sy[2];
		cs_rise = q.cs_sy[1] & ~q.cs_sy[2];

		// Writes stay blocked until supply has had time to settle
		if (!q.pu_done) begin
			d.pu_cnt = q.pu_cnt + 16'h1;
			if (q.pu_cnt == 16'(`FPH_PUW_CYCLES - 1)) begin
				d.pu_done = 1'b1;
			end
		end

		// Internal write cycle runs regardless of link or hold
		if (q.busy) begin
			d.busy_cnt = q.busy_cnt - 16'h1;
			if (q.busy_cnt == 16'h1) begin
				d.busy = 1'b0;
			end
		end

		// Level view of the edge rules: follow pause only while clock low
		if (!sel) begin
			d.held = 1'b0;
		end else if (sclk_low) begin
			d.held = ~q.hold_sy[1];
		end

		// Clock edges while held are ignored; counters stay frozen
		if (sel && !q.held) begin
			if (rise) begin
				byte_in = {q.shift[6:0], q.si_sy[1]};
				d.shift = byte_in;
				d.bit_cnt = q.bit_cnt + 3'h1;
				if (q.bit_cnt == `FPH_BITS_LAST) begin
					if (q.byte_cnt != `FPH_LEN_MAX) begin
						d.byte_cnt = q.byte_cnt + 4'h1;
					end
					if (q.byte_cnt == 4'h0) begin
						d.opcode = byte_in;
						d.reading = (byte_in == `FPH_OP_READ_STATUS) && !q.deep;
					end
					if (q.byte_cnt == `FPH_LEN_SHORT) begin
						d.sector = byte_in[5:0];
					end
				end
			end
			if (fall && q.reading) begin
				// Reload each byte so busy is fresh while polling
				d.out_sh = (q.bit_cnt == 3'h0) ? q.status : {q.out_sh[6:0], 1'b0};
			end
		end

		// Modifying instruction is judged when select rises
		modifying = (q.opcode == `FPH_OP_WRITE_STATUS) || (q.opcode == `FPH_OP_PAGE_PROGRAM) ||
			(q.opcode == `FPH_OP_SECTOR_ERASE) || (q.opcode == `FPH_OP_BULK_ERASE);
		whole = (q.bit_cnt == 3'h0);

		if (cs_rise && !q.held) begin
			if (q.deep) begin
				if (q.opcode == `FPH_OP_WAKE_READ_ID && q.byte_cnt >= `FPH_LEN_SHORT) begin
					d.deep = 1'b0;
				end
			end else if (whole && !q.busy) begin
				case (q.opcode)
					`FPH_OP_SET_WRITE_LATCH: begin
						if (q.byte_cnt == `FPH_LEN_SHORT && q.pu_done) begin
							d.write_enable_latch = 1'b1;
						end
					end
					`FPH_OP_CLEAR_WRITE_LATCH: begin
						if (q.byte_cnt == `FPH_LEN_SHORT) begin
							d.write_enable_latch = 1'b0;
							d.otp_mode = 1'b0;
						end
					end
					`FPH_OP_DEEP_SLEEP: begin
						if (q.byte_cnt == `FPH_LEN_SHORT) begin
							d.deep = 1'b1;
						end
					end
					`FPH_OP_ENTER_OTP: begin
						if (q.byte_cnt == `FPH_LEN_SHORT) begin
							d.otp_mode = 1'b1;
						end
					end
					`FPH_OP_WRITE_STATUS: begin
						if (q.byte_cnt == `FPH_LEN_STATUS && q.write_enable_latch && q.pu_done) begin
							if (q.otp_mode) begin
								// Data byte discarded; lock only ever goes to one
								d.otp_lock = 1'b1;
								start = 1'b1;
							end else if (!(q.guard && !q.wp_sy[1])) begin
								d.guard = q.shift[`FPH_ST_GUARD];
								d.bp = q.shift[`FPH_ST_BP_HI:`FPH_ST_BP_LO];
								start = 1'b1;
							end
						end
					end
					`FPH_OP_PAGE_PROGRAM, `FPH_OP_SECTOR_ERASE: begin
						if (((q.opcode == `FPH_OP_PAGE_PROGRAM && q.byte_cnt >= `FPH_LEN_PROGRAM_MIN) ||
							(q.opcode == `FPH_OP_SECTOR_ERASE && q.byte_cnt == `FPH_LEN_ERASE)) &&
							q.write_enable_latch && q.pu_done) begin
							if (q.otp_mode) begin
								start = !q.otp_lock;
							end else begin
								start = !fph_protected(q.bp, q.sector);
							end
						end
					end
					`FPH_OP_BULK_ERASE: begin
						// Any protected sector blocks a whole-array erase
						if (q.byte_cnt == `FPH_LEN_SHORT && q.write_enable_latch && q.pu_done && !q.otp_mode &&
							q.bp == `FPH_BP_NONE) begin
							start = 1'b1;
						end
					end
					default: begin
						start = 1'b0;
					end
				endcase
			end
			if (start) begin
				d.busy = 1'b1;
				d.busy_cnt = 16'(`FPH_WRITE_CYCLES);
				d.write_enable_latch = 1'b0;
				d.op_accept = 1'b1;
			end else if (modifying && !q.deep && !q.busy) begin
				// Frames ignored in deep sleep or while busy are never judged
				d.op_reject = 1'b1;
			end
		end

		// Deselect ends the frame; during hold it also resets the link logic
		if (cs_rise) begin
			d.bit_cnt = 3'h0;
			d.byte_cnt = 4'h0;
			d.reading = 1'b0;
			d.shift = 8'h00;
			d.opcode = 8'h00;
			d.held = 1'b0;
		end

		// Resume driving when hold ends so the line never floats mid-read
		d.out_oe = d.reading && !d.held && !q.cs_sy[1] &&
			(d.bit_cnt != 3'h0 || fall || q.out_oe || q.held);

		if (d.deep) begin
			d.power_mode = FPH_PM_DEEP;
		end else if (!q.cs_sy[1] || d.busy) begin
			d.power_mode = FPH_PM_ACTIVE;
		end else begin
			d.power_mode = FPH_PM_STANDBY;
		end

		d.status = 8'h00;
		d.status[`FPH_ST_BUSY] = d.busy;
		d.status[`FPH_ST_WEL] = d.write_enable_latch;
		d.status[`FPH_ST_BP_HI:`FPH_ST_BP_LO] = d.bp;
		d.status[`FPH_ST_GUARD] = d.otp_mode ? d.otp_lock : d.guard;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
			q.sclk_sy <= 3'h0;
			q.cs_sy <= 3'h7;
			q.hold_sy <= 2'h3;
			q.wp_sy <= 2'h3;
			q.power_mode <= FPH_PM_STANDBY;
		end else begin
			q <= d;
		end
	end

	assign lnk.serial_out = q.out_sh[7];
	assign lnk.serial_out_oe = q.out_oe;
	assign power_mode = q.power_mode;
	assign status = q.status;
	assign otp_mode = q.otp_mode;
	assign op_accept = q.op_accept;
	assign op_reject = q.op_reject;

endmodule : fph_device

// *** rtl/fph_params.svh ***
// Purpose: constants shared by both ends of the flash protection link
// Assumes: system clock of 40 MHz
// Notes: times are given in microseconds and turned into cycle counts
`ifndef FPH_PARAMS_SVH
`define FPH_PARAMS_SVH

// Instruction codes
`define FPH_OP_SET_WRITE_LATCH 8'h06
`define FPH_OP_CLEAR_WRITE_LATCH 8'h04
`define FPH_OP_READ_STATUS 8'h05
`define FPH_OP_WRITE_STATUS 8'h01
`define FPH_OP_PAGE_PROGRAM 8'h02
`define FPH_OP_SECTOR_ERASE 8'hd8
`define FPH_OP_BULK_ERASE 8'hc7
`define FPH_OP_DEEP_SLEEP 8'hb9
`define FPH_OP_WAKE_READ_ID 8'hab
`define FPH_OP_ENTER_OTP 8'h3a

// Frame lengths in whole bytes
`define FPH_LEN_SHORT 4'h1
`define FPH_LEN_STATUS 4'h2
`define FPH_LEN_ERASE 4'h4
`define FPH_LEN_PROGRAM_MIN 4'h5
`define FPH_LEN_MAX 4'hf
`define FPH_BITS_LAST 3'h7

// Status bit positions
`define FPH_ST_BUSY 0
`define FPH_ST_WEL 1
`define FPH_ST_BP_LO 2
`define FPH_ST_BP_HI 4
`define FPH_ST_GUARD 7

// Sector count and protection code
`define FPH_SECTORS 7'h40
`define FPH_BP_NONE 3'h0
`define FPH_BP_ALL 3'h7

// Timing
`define FPH_CLK_MHZ 40
`define FPH_PUW_US 10
`define FPH_PUW_CYCLES (`FPH_PUW_US * `FPH_CLK_MHZ)
`define FPH_WRITE_US 5
`define FPH_WRITE_CYCLES (`FPH_WRITE_US * `FPH_CLK_MHZ)
`define FPH_SCLK_HALF 4'h8

// Host register offsets and control fields
`define FPH_REG_DATA 2'h0
`define FPH_REG_CTRL 2'h1
`define FPH_REG_STAT 2'h2
`define FPH_CTRL_SELECT 0
`define FPH_CTRL_HOLD 1
`define FPH_CTRL_WPROT 2
`define FPH_CTRL_NBITS_LO 3
`define FPH_CTRL_NBITS_HI 5

`endif

// *** rtl/fph_pkg.sv ***
// Purpose: types of the flash protection link ends
// Assumes: constants from fph_params.svh
// Notes: status byte layout is fixed by the params header
package fph_pkg;
`include "fph_params.svh"

	typedef enum logic [1:0] {
		FPH_PM_STANDBY = 2'h0,
		FPH_PM_ACTIVE = 2'h1,
		FPH_PM_DEEP = 2'h2
	} fph_power_type;

	typedef enum logic {
		FPH_HS_IDLE = 1'h0,
		FPH_HS_SHIFT = 1'h1
	} fph_hstate_type;

	typedef struct packed {
		logic [2:0] sclk_sy;
		logic [2:0] cs_sy;
		logic [1:0] si_sy;
		logic [1:0] hold_sy;
		logic [1:0] wp_sy;
		logic held;
		logic [2:0] bit_cnt;
		logic [3:0] byte_cnt;
		logic [7:0] shift;
		logic [7:0] opcode;
		logic [5:0] sector;
		logic reading;
		logic [7:0] out_sh;
		logic out_oe;
		logic busy;
		logic [15:0] busy_cnt;
		logic [15:0] pu_cnt;
		logic pu_done;
		logic write_enable_latch;
		logic [2:0] bp;
		logic guard;
		logic otp_lock;
		logic otp_mode;
		logic deep;
		fph_power_type power_mode;
		logic [7:0] status;
		logic op_accept;
		logic op_reject;
	} fph_dev_type;

	typedef struct packed {
		logic [1:0] so_sy;
		fph_hstate_type state;
		logic [3:0] half_cnt;
		logic [3:0] bits_left;
		logic [2:0] nbits;
		logic [7:0] tx;
		logic [7:0] rx;
		logic select_n;
		logic hold_n;
		logic wp_n;
		logic sclk;
		logic sin;
		logic [7:0] rdata;
	} fph_host_type;

	// Upper 1, 2, 4 ... 32 sectors, or all for code 7
	function automatic logic fph_protected(input logic [2:0] bp, input logic [5:0] sector);
		logic [6:0] first;
		first = `FPH_SECTORS - (7'h1 << (bp - 3'h1));
		if (bp == `FPH_BP_NONE) begin
			return 1'b0;
		end
		if (bp == `FPH_BP_ALL) begin
			return 1'b1;
		end
		return {1'b0, sector} >= first;
	endfunction : fph_protected

endpackage : fph_pkg

// *** rtl/fph_link_if.sv ***
// Purpose: serial link between host and flash protection logic
// Assumes: host makes the serial clock, mode 0
// Notes: serial_out is a tri-state pin, resolved in the host, which reads it as high when undriven
interface fph_link_if;
	logic select_n;
	logic sclk;
	logic serial_in;
	logic serial_out;
	logic serial_out_oe;
	logic hold_n;
	logic write_protect_n;

	modport dev (
		input select_n, sclk, serial_in, hold_n, write_protect_n,
		output serial_out, serial_out_oe
	);
	modport host (
		output select_n, sclk, serial_in, hold_n, write_protect_n,
		input serial_out, serial_out_oe
	);
endinterface : fph_link_if

// *** rtl/fph_host.sv ***
// Purpose: host end; shifts bytes on the link under register control
// Assumes: mode 0, serial clock made here by a divider
// Notes: select and write protect are plain register bits; hold is forced released on reselect
module fph_host
	import fph_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Link
	fph_link_if.host lnk
);

	fph_host_type q;
	fph_host_type d;

	always_comb begin
		d = q;
		// Undriven line reads as pulled up
		d.so_sy = {q.so_sy[0], lnk.serial_out_oe ? lnk.serial_out : 1'b1};

		if (reg_wr && reg_addr == `FPH_REG_CTRL) begin
			d.select_n = ~reg_wdata[`FPH_CTRL_SELECT];
			d.wp_n = ~reg_wdata[`FPH_CTRL_WPROT];
			d.nbits = reg_wdata[`FPH_CTRL_NBITS_HI:`FPH_CTRL_NBITS_LO];
			// Reselecting always releases pause first so hold is not re-entered
			if (q.select_n && reg_wdata[`FPH_CTRL_SELECT]) begin
				d.hold_n = 1'b1;
			end else begin
				d.hold_n = ~reg_wdata[`FPH_CTRL_HOLD];
			end
		end

		if (reg_wr && reg_addr == `FPH_REG_DATA && q.state == FPH_HS_IDLE && !q.select_n) begin
			d.state = FPH_HS_SHIFT;
			d.tx = reg_wdata;
			d.sin = reg_wdata[7];
			d.sclk = 1'b0;
			d.half_cnt = 4'h0;
			// Partial byte lets software provoke a rejected frame
			d.bits_left = (q.nbits == 3'h0) ? 4'h8 : {1'b0, q.nbits};
		end

		// Shifting pauses while hold is asserted
		if (q.state == FPH_HS_SHIFT && q.hold_n) begin
			d.half_cnt = q.half_cnt + 4'h1;
			if (q.half_cnt == `FPH_SCLK_HALF - 4'h1) begin
				d.half_cnt = 4'h0;
				if (!q.sclk) begin
					d.sclk = 1'b1;
					d.rx = {q.rx[6:0], q.so_sy[1]};
				end else begin
					d.sclk = 1'b0;
					d.tx = {q.tx[6:0], 1'b0};
					d.sin = q.tx[6];
					d.bits_left = q.bits_left - 4'h1;
					if (q.bits_left == 4'h1) begin
						d.state = FPH_HS_IDLE;
					end
				end
			end
		end

		d.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`FPH_REG_DATA: d.rdata = q.rx;
				`FPH_REG_CTRL: begin
					d.rdata[`FPH_CTRL_SELECT] = ~q.select_n;
					d.rdata[`FPH_CTRL_HOLD] = ~q.hold_n;
					d.rdata[`FPH_CTRL_WPROT] = ~q.wp_n;
					d.rdata[`FPH_CTRL_NBITS_HI:`FPH_CTRL_NBITS_LO] = q.nbits;
				end
				`FPH_REG_STAT: d.rdata[0] = (q.state == FPH_HS_SHIFT);
				default: d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
			q.state <= FPH_HS_IDLE;
			q.select_n <= 1'b1;
			q.hold_n <= 1'b1;
			q.wp_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata = q.rdata;
	assign lnk.select_n = q.select_n;
	assign lnk.sclk = q.sclk;
	assign lnk.serial_in = q.sin;
	assign lnk.hold_n = q.hold_n;
	assign lnk.write_protect_n = q.wp_n;

endmodule : fph_host

// *** sim/fph_checker.sv ***
// Purpose: concurrent checks on the link and the device state
// Assumes: link pins pass a two-flop synchroniser in the device
// Notes: windows of six cycles, and four for the hold check, cover the synchroniser lag
`include "fph_params.svh"
module fph_checker
	import fph_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Link
	input wire logic select_n,
	input wire logic sclk,
	input wire logic hold_n,
	input wire logic write_protect_n,
	input wire logic serial_out_oe,
	// Device state
	input wire fph_power_type power_mode,
	input wire logic [7:0] status,
	input wire logic otp_mode,
	input wire logic op_accept,
	input wire logic op_reject
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] pu_q, pu_d, run_q, run_d;

	always_comb begin
		pu_d = (pu_q < `FPH_PUW_CYCLES) ? pu_q + 16'h1 : pu_q;
		run_d = status[0] ? run_q + 16'h1 : 16'h0;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pu_q <= 16'h0;
			run_q <= 16'h0;
		end else begin
			pu_q <= pu_d;
			run_q <= run_d;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	sequence s_held;
		(!select_n && !hold_n && !sclk) [*4];
	endsequence
	sequence s_locked;
		(status[7] && !write_protect_n && !otp_mode) [*6];
	endsequence

	a_active_selected: assert property (
		(!select_n && power_mode != FPH_PM_DEEP) [*6] |-> power_mode == FPH_PM_ACTIVE)
		else $error("not active while selected");
	a_standby_idle: assert property (
		(select_n && !status[0] && power_mode != FPH_PM_DEEP) [*6]
		|-> power_mode == FPH_PM_STANDBY)
		else $error("not standby when idle");
	a_busy_active: assert property (status[0] && $past(status[0])
		|-> power_mode == FPH_PM_ACTIVE)
		else $error("left active while busy");
	a_busy_span: assert property ($fell(status[0])
		|-> run_q >= `FPH_WRITE_CYCLES && run_q <= `FPH_WRITE_CYCLES + 1)
		else $error("busy span wrong");
	a_accept_latch: assert property (op_accept
		|-> $past(status[1]) && status[0] && !status[1])
		else $error("accept without latch");
	a_deep_quiet: assert property (power_mode == FPH_PM_DEEP
		|-> !op_accept && !op_reject)
		else $error("instruction judged in deep sleep");
	a_powerup_block: assert property ((op_accept || $rose(status[1]))
		|-> pu_q >= `FPH_PUW_CYCLES)
		else $error("change during power-up delay");
	a_hold_float: assert property (s_held |-> !serial_out_oe)
		else $error("output driven in hold");
	a_hpm_frozen: assert property (s_locked |=> $stable(status[7:2]))
		else $error("protect bits changed while locked");
	a_lock_once: assert property (otp_mode && status[7]
		|=> !otp_mode || status[7])
		else $error("sector lock cleared");
endmodule : fph_checker

// *** sim/flash_protect_power_hold_tb.sv ***
// Purpose: drives the host registers and judges the device state
// Assumes: CTRL b1 high pauses the link, b2 high asserts write protect
// Notes: accept and reject pulses are counted on the falling clock edge
`include "fph_params.svh"
module flash_protect_power_hold_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import fph_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata, status;
	logic otp_mode, op_accept, op_reject;
	fph_power_type power_mode;
	logic [2:0] ctl = 3'h0;
	int n_fail = 0, check_count = 0, n_acc = 0, n_rej = 0;
	fph_link_if lnk();
	fph_device fph_device_i(.clk(clk), .nrst(nrst), .lnk(lnk.dev), .power_mode(power_mode),
		.status(status), .otp_mode(otp_mode), .op_accept(op_accept), .op_reject(op_reject));
	fph_host fph_host_i(.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lnk(lnk.host));
	fph_checker fph_checker_i(.clk(clk), .nrst(nrst), .select_n(lnk.select_n), .sclk(lnk.sclk),
		.hold_n(lnk.hold_n), .write_protect_n(lnk.write_protect_n),
		.serial_out_oe(lnk.serial_out_oe), .power_mode(power_mode), .status(status),
		.otp_mode(otp_mode), .op_accept(op_accept), .op_reject(op_reject));
	always #12.5 clk = ~clk;
	// Pulses last one cycle, so count them away from the launching edge
	always @(negedge clk) begin
		if (op_accept === 1'b1) n_acc++;
		if (op_reject === 1'b1) n_rej++;
	end
	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_read
	task automatic set_ctrl(input logic [2:0] nbits);
		reg_write(`FPH_REG_CTRL, {2'h0, nbits, ctl});
	endtask : set_ctrl
	task automatic wait_shift();
		logic [7:0] s;
		int i;
		for (i = 0; i < 100; i++) begin
			reg_read(`FPH_REG_STAT, s);
			if (s[0] === 1'b0) break;
		end
		if (i == 100) check("shift done", 8'h00, s);
	endtask : wait_shift
	task automatic send(input logic [7:0] b);
		reg_write(`FPH_REG_DATA, b);
		wait_shift();
	endtask : send
	task automatic frame(input logic [7:0] q[], input logic [2:0] last_bits);
		ctl[0] = 1'b1;
		set_ctrl(3'h0);
		foreach (q[i]) begin
			if (i == q.size() - 1 && last_bits != 3'h0) set_ctrl(last_bits);
			send(q[i]);
		end
		ctl[0] = 1'b0;
		set_ctrl(3'h0);
		repeat (8) @(posedge clk);
	endtask : frame
	task automatic wait_busy();
		for (int i = 0; i < 600; i++) begin
			@(posedge clk);
			if (status[0] === 1'b0) break;
		end
		repeat (8) @(posedge clk);
	endtask : wait_busy
	task automatic write_status_cmd(input logic [7:0] d);
		frame('{8'h06}, 3'h0);
		frame('{8'h01, d}, 3'h0);
		wait_busy();
	endtask : write_status_cmd
	// Lowest protected sector for each protect code
	function automatic logic exp_prot(input logic [2:0] bp, input logic [5:0] sec);
		logic [6:0] first [8] = '{7'h40, 7'h3f, 7'h3e, 7'h3c, 7'h38, 7'h30, 7'h20, 7'h00};
		return {1'b0, sec} >= first[bp];
	endfunction : exp_prot
	initial begin
		repeat (90000) @(posedge clk);
		n_fail++;
		$display("Error watchdog expected done seen timeout");
		report_and_stop();
	end
	initial begin
		logic [7:0] s;
		logic [5:0] secs [3];
		int a0;
		void'($urandom(23864));
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		check("status at reset", 8'h00, status);
		frame('{8'h06}, 3'h0);
		check("latch in delay", 8'h00, status);
		repeat (400) @(posedge clk);
		frame('{8'h06}, 3'h0);
		check("latch set", 8'h02, status);
		frame('{8'h04}, 3'h0);
		check("latch clear", 8'h00, status);
		a0 = n_rej;
		frame('{8'hd8, 8'h00, 8'h00, 8'h00}, 3'h0);
		check("erase no latch", 8'h01, 8'(n_rej - a0));
		for (int k = 0; k < 8; k++) begin
			write_status_cmd({3'h0, 3'(k), 2'h0});
			check("protect bits", {3'h0, 3'(k), 2'h0}, status);
			secs = '{6'($urandom_range(63)), 6'h1f, 6'h3f};
			foreach (secs[j]) begin
				a0 = n_acc;
				frame('{8'h06}, 3'h0);
				frame('{8'hd8, {2'h0, secs[j]}, 8'h00, 8'h00}, 3'h0);
				check("erase accept", {7'h0, !exp_prot(3'(k), secs[j])}, 8'(n_acc - a0));
				wait_busy();
				frame('{8'h04}, 3'h0);
			end
		end
		write_status_cmd(8'h00);
		frame('{8'h06}, 3'h0);
		frame('{8'hc7}, 3'h0);
		check("active while busy", 8'h01, {6'h0, power_mode});
		wait_busy();
		check("standby after", 8'h00, {6'h0, power_mode});
		a0 = n_rej;
		frame('{8'h06}, 3'h0);
		frame('{8'h02, 8'h00, 8'h00, 8'h00, 8'h5a}, 3'h7);
		check("partial byte", 8'h01, 8'(n_rej - a0));
		frame('{8'h04}, 3'h0);
		frame('{8'hb9}, 3'h0);
		check("deep entered", 8'h02, {6'h0, power_mode});
		frame('{8'h06}, 3'h0);
		check("deep ignores", 8'h00, status);
		a0 = n_rej + n_acc;
		frame('{8'hc7}, 3'h0);
		check("deep no judge", 8'h00, 8'(n_rej + n_acc - a0));
		frame('{8'hab}, 3'h0);
		check("woken", 8'h00, {6'h0, power_mode});
		write_status_cmd(8'h80);
		ctl[2] = 1'b1;
		set_ctrl(3'h0);
		frame('{8'h06}, 3'h0);
		frame('{8'h01, 8'h00}, 3'h0);
		check("locked bits", 8'h80, status & 8'hfc);
		ctl[2] = 1'b0;
		frame('{8'h04}, 3'h0);
		write_status_cmd(8'h00);
		frame('{8'h3a}, 3'h0);
		check("otp mode", 8'h01, {7'h0, otp_mode});
		write_status_cmd(8'h1c);
		check("otp lock set", 8'h80, status);
		write_status_cmd(8'h00);
		check("otp lock kept", 8'h80, status);
		frame('{8'h04}, 3'h0);
		frame('{8'h06}, 3'h0);
		ctl[0] = 1'b1;
		set_ctrl(3'h0);
		send(8'h05);
		send(8'h00);
		ctl[1] = 1'b1;
		set_ctrl(3'h0);
		repeat (10) @(posedge clk);
		check("float in hold", 8'h00, {7'h0, lnk.serial_out_oe});
		ctl[1] = 1'b0;
		set_ctrl(3'h0);
		send(8'h00);
		reg_read(`FPH_REG_DATA, s);
		check("status after hold", 8'h02, s);
		ctl[0] = 1'b0;
		set_ctrl(3'h0);
		frame('{8'h04}, 3'h0);
		for (int m = 0; m < 2; m++) begin
			ctl[0] = 1'b1;
			set_ctrl(3'h0);
			reg_write(`FPH_REG_DATA, 8'h06);
			// Pause lands mid-byte while the serial clock is low
			repeat (34) @(posedge clk);
			ctl[1] = 1'b1;
			set_ctrl(3'h0);
			repeat (60) @(posedge clk);
			if (m == 1) begin
				ctl[0] = 1'b0;
				set_ctrl(3'h0);
			end
			ctl[1] = 1'b0;
			set_ctrl(3'h0);
			wait_shift();
			ctl[0] = 1'b0;
			set_ctrl(3'h0);
			repeat (8) @(posedge clk);
			check("latch after hold", (m == 0) ? 8'h02 : 8'h00, status);
			frame('{8'h04}, 3'h0);
		end
		report_and_stop();
	end
endmodule : flash_protect_power_hold_tb
